// File: core/obu_defines.svh
// Register offsets, field positions and reset values of the break unit
`ifndef OBU_DEFINES_SVH
`define OBU_DEFINES_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OBU_OFS_CTRL 8'h00
`define OBU_OFS_STATUS 8'h04
`define OBU_OFS_PC_EN 8'h08
`define OBU_OFS_PC_BASE 8'h10
`define OBU_OFS_EVA_ADDR 8'h30
`define OBU_OFS_EVA_CFG 8'h34
`define OBU_OFS_EVA_DATA 8'h38
`define OBU_OFS_EVB_ADDR 8'h3C
`define OBU_OFS_EVB_CFG 8'h40
`define OBU_OFS_BRK_CFG 8'h44
`define OBU_OFS_TRC_CFG 8'h48
`define OBU_OFS_TRC_IDX 8'h50
`define OBU_OFS_TRC_LO 8'h54
`define OBU_OFS_TRC_HI 8'h58
// ------------------------------------------------------------
// Control command bits
// ------------------------------------------------------------
`define OBU_CTRL_FORCE 0
`define OBU_CTRL_RESUME 1
`define OBU_CTRL_TCLR 2
// ------------------------------------------------------------
// Event config fields: mask count, size, direction, enable
// ------------------------------------------------------------
`define OBU_EV_MASK_LSB 0
`define OBU_EV_SIZE_LSB 5
`define OBU_EV_DIR_LSB 7
`define OBU_EV_EN 9
`define OBU_EVD_MASK_LSB 16
// ------------------------------------------------------------
// Break and trace config fields
// ------------------------------------------------------------
`define OBU_BRK_COND_LSB 0
`define OBU_BRK_EN 3
`define OBU_BRK_TFULL 4
`define OBU_TRC_MODE 0
`define OBU_TRC_START_LSB 1
`define OBU_TRC_STOP_LSB 4
`define OBU_TRC_PICK 7
`define OBU_TRC_EN 8
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define OBU_RST_EV_CFG 10'h000
`define OBU_RST_EVA_DMASK 16'hFFFF
`define OBU_RST_BRK_CFG 5'h00
`define OBU_RST_TRC_CFG 9'h000
`endif

// File: core/obu_pkg.sv
// Types shared by the break unit
package obu_pkg;
   typedef enum logic [1:0] {
      OBU_RUN = 2'b00,
      OBU_HALTED = 2'b01,
      OBU_STEP = 2'b10
   } obu_state_type;
   typedef enum logic [1:0] {
      OBU_SZ_ANY = 2'b00,
      OBU_SZ_BYTE = 2'b01,
      OBU_SZ_WORD = 2'b10
   } obu_size_type;
   typedef enum logic [1:0] {
      OBU_DIR_RW = 2'b00,
      OBU_DIR_RD = 2'b01,
      OBU_DIR_WR = 2'b10
   } obu_dir_type;
   // Event combinations; start uses NONE as "on run", stop as "on halt"
   typedef enum logic [2:0] {
      OBU_EC_NONE = 3'h0,
      OBU_EC_A = 3'h1,
      OBU_EC_A_OR_B = 3'h2,
      OBU_EC_A_AND_B = 3'h3,
      OBU_EC_B_THEN_A = 3'h4,
      OBU_EC_FULL = 3'h5
   } obu_cond_type;
endpackage

// File: core/obu_top.sv
// On-chip break and trace unit facing the core and the debugger
`timescale 1ns/1ps
`include "obu_defines.svh"
module obu_top #(
   parameter int AW = 20,
   parameter int DEPTH = 16,
   parameter int NPC = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic insn_valid,
   input wire logic [AW-1:0] insn_addr,
   input wire logic dacc_valid,
   input wire logic [AW-1:0] dacc_addr,
   input wire logic [15:0] dacc_data,
   input wire logic dacc_word,
   input wire logic dacc_write,
   input wire logic br_valid,
   input wire logic [AW-1:0] br_src,
   input wire logic [AW-1:0] br_dst,
   input wire logic debug_break_opcode_hit,
   input wire logic core_halt_ack,
   output logic halt_req,
   output logic addr_match_req,
   output logic core_resume,
   output logic core_step
);
   localparam int PW = $clog2(DEPTH + 1);
   localparam int IW = $clog2(DEPTH);
   localparam int EW = 2 * AW + 1;

   obu_pkg::obu_state_type state_ff;
   logic [31:0] rdata_ff;
   logic halt_ff, amr_ff, resume_ff, step_ff;
   logic [NPC-1:0] pc_en_ff;
   logic [AW-1:0] pc_addr_ff [NPC];
   logic [AW-1:0] eva_addr_ff, evb_addr_ff;
   logic [9:0] eva_cfg_ff, evb_cfg_ff;
   logic [15:0] eva_data_ff, eva_dmask_ff;
   logic [4:0] brk_cfg_ff;
   logic [8:0] trc_cfg_ff;
   logic a_seen_ff, b_seen_ff, b_armed_ff;
   logic [4:0] cause_ff;
   logic trc_act_ff;
   logic [PW-1:0] trc_cnt_ff;
   logic [IW-1:0] trc_idx_ff;
   logic [EW-1:0] trc_mem_ff [DEPTH];

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic ctl_wr, force_cmd, resume_cmd, cfg_ok, run_start;
   assign ctl_wr = reg_wr && (reg_addr == `OBU_OFS_CTRL);
   assign force_cmd = ctl_wr && reg_wdata[`OBU_CTRL_FORCE];
   assign resume_cmd = ctl_wr && reg_wdata[`OBU_CTRL_RESUME];
   assign cfg_ok = (state_ff == obu_pkg::OBU_HALTED);
   assign run_start = resume_cmd && cfg_ok;

   // ------------------------------------------------------------
   // Comparators
   // ------------------------------------------------------------
   // Access signals are arguments so each caller re-evaluates on them
   function automatic logic acc_ok(input logic [AW-1:0] ref_addr,
                                   input logic [9:0] cfg,
                                   input logic vld,
                                   input logic wrd,
                                   input logic wrt,
                                   input logic [AW-1:0] adr);
      logic [AW-1:0] m;
      logic sz_ok, dir_ok;
      m = {AW{1'b1}} << cfg[`OBU_EV_MASK_LSB +: 5];
      case (obu_pkg::obu_size_type'(cfg[`OBU_EV_SIZE_LSB +: 2]))
         obu_pkg::OBU_SZ_BYTE: sz_ok = !wrd;
         obu_pkg::OBU_SZ_WORD: sz_ok = wrd;
         default: sz_ok = 1'b1;
      endcase
      case (obu_pkg::obu_dir_type'(cfg[`OBU_EV_DIR_LSB +: 2]))
         obu_pkg::OBU_DIR_RD: dir_ok = !wrt;
         obu_pkg::OBU_DIR_WR: dir_ok = wrt;
         default: dir_ok = 1'b1;
      endcase
      acc_ok = vld && cfg[`OBU_EV_EN] && sz_ok && dir_ok
         && (((adr ^ ref_addr) & m) == {AW{1'b0}});
   endfunction

   logic [15:0] dmask;
   logic a_hit, b_hit;
   // Byte accesses only carry eight meaningful data bits
   assign dmask = eva_dmask_ff & (dacc_word ? 16'hFFFF : 16'h00FF);
   assign a_hit = acc_ok(eva_addr_ff, eva_cfg_ff, dacc_valid, dacc_word,
      dacc_write, dacc_addr)
      && (((dacc_data ^ eva_data_ff) & dmask) == 16'h0000);
   assign b_hit = acc_ok(evb_addr_ff, evb_cfg_ff, dacc_valid, dacc_word,
      dacc_write, dacc_addr);

   logic [NPC-1:0] pc_hit;
   genvar gi;
   generate
      for (gi = 0; gi < NPC; gi++) begin : g_pc
         assign pc_hit[gi] = pc_en_ff[gi] && (insn_addr == pc_addr_ff[gi]);
      end
   endgenerate

   // Combinations passed in whole so callers follow every hit and flag
   logic [3:0] ev_vec;
   assign ev_vec = {a_hit && b_armed_ff, (a_hit || b_hit)
      && (a_hit || a_seen_ff) && (b_hit || b_seen_ff), a_hit || b_hit, a_hit};

   function automatic logic ev_sel(input logic [2:0] c,
                                   input logic [3:0] v);
      case (obu_pkg::obu_cond_type'(c))
         obu_pkg::OBU_EC_A: ev_sel = v[0];
         obu_pkg::OBU_EC_A_OR_B: ev_sel = v[1];
         obu_pkg::OBU_EC_A_AND_B: ev_sel = v[2];
         obu_pkg::OBU_EC_B_THEN_A: ev_sel = v[3];
         default: ev_sel = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Halt sources
   // ------------------------------------------------------------
   logic running, pc_brk, data_brk, trc_full, tfull_brk, halt_set;
   assign running = (state_ff == obu_pkg::OBU_RUN);
   assign trc_full = (trc_cnt_ff == PW'(DEPTH));
   // The stepped instruction sits on a break address; no re-trigger
   assign pc_brk = running && insn_valid && (|pc_hit);
   assign data_brk = running && brk_cfg_ff[`OBU_BRK_EN]
      && ev_sel(brk_cfg_ff[`OBU_BRK_COND_LSB +: 3], ev_vec);
   // Full is a level; gated so the acknowledge can drop the request
   assign tfull_brk = running && brk_cfg_ff[`OBU_BRK_TFULL] && !halt_ff
      && trc_cfg_ff[`OBU_TRC_EN] && trc_full;
   assign halt_set = (running && force_cmd) || pc_brk || data_brk
      || tfull_brk;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         a_seen_ff <= 1'b0;
         b_seen_ff <= 1'b0;
         b_armed_ff <= 1'b0;
      end else if (run_start) begin
         a_seen_ff <= 1'b0;
         b_seen_ff <= 1'b0;
         b_armed_ff <= 1'b0;
      end else begin
         a_seen_ff <= a_seen_ff || a_hit;
         b_seen_ff <= b_seen_ff || b_hit;
         b_armed_ff <= b_armed_ff || b_hit;
      end
   end

   // Set wins over the acknowledge in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         halt_ff <= 1'b0;
         amr_ff <= 1'b0;
      end else begin
         halt_ff <= halt_set || (halt_ff && !core_halt_ack);
         amr_ff <= pc_brk || (amr_ff && !core_halt_ack);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cause_ff <= 5'h00;
      end else if (run_start) begin
         cause_ff <= 5'h00;
      end else if (running) begin
         cause_ff <= cause_ff | {debug_break_opcode_hit, tfull_brk,
                                 data_brk, pc_brk, force_cmd};
      end
   end

   // ------------------------------------------------------------
   // Run, halt and step sequence
   // ------------------------------------------------------------
   logic bp_cause;
   assign bp_cause = cause_ff[1] || cause_ff[4];
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= obu_pkg::OBU_RUN;
         resume_ff <= 1'b0;
         step_ff <= 1'b0;
      end else begin
         resume_ff <= 1'b0;
         case (state_ff)
            obu_pkg::OBU_RUN: begin
               if (core_halt_ack) begin
                  state_ff <= obu_pkg::OBU_HALTED;
               end
            end
            obu_pkg::OBU_HALTED: begin
               if (resume_cmd) begin
                  resume_ff <= 1'b1;
                  step_ff <= bp_cause;
                  state_ff <= bp_cause ? obu_pkg::OBU_STEP
                                       : obu_pkg::OBU_RUN;
               end
            end
            obu_pkg::OBU_STEP: begin
               if (core_halt_ack) begin
                  resume_ff <= 1'b1;
                  step_ff <= 1'b0;
                  state_ff <= obu_pkg::OBU_RUN;
               end
            end
            default: state_ff <= obu_pkg::OBU_RUN;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pc_en_ff <= '0;
         for (int i = 0; i < NPC; i++) begin
            pc_addr_ff[i] <= '0;
         end
      end else if (reg_wr) begin
         // Fetch comparators stay writable while the core runs
         if (reg_addr == `OBU_OFS_PC_EN) begin
            pc_en_ff <= reg_wdata[NPC-1:0];
         end
         for (int i = 0; i < NPC; i++) begin
            if (reg_addr == (`OBU_OFS_PC_BASE + 8'(4 * i))) begin
               pc_addr_ff[i] <= reg_wdata[AW-1:0];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         eva_addr_ff <= '0;
         evb_addr_ff <= '0;
         eva_cfg_ff <= `OBU_RST_EV_CFG;
         evb_cfg_ff <= `OBU_RST_EV_CFG;
         eva_data_ff <= 16'h0000;
         eva_dmask_ff <= `OBU_RST_EVA_DMASK;
         brk_cfg_ff <= `OBU_RST_BRK_CFG;
         trc_cfg_ff <= `OBU_RST_TRC_CFG;
      end else if (reg_wr && cfg_ok) begin
         case (reg_addr)
            `OBU_OFS_EVA_ADDR: eva_addr_ff <= reg_wdata[AW-1:0];
            `OBU_OFS_EVA_CFG: eva_cfg_ff <= reg_wdata[9:0];
            `OBU_OFS_EVA_DATA: begin
               eva_data_ff <= reg_wdata[15:0];
               eva_dmask_ff <= reg_wdata[`OBU_EVD_MASK_LSB +: 16];
            end
            `OBU_OFS_EVB_ADDR: evb_addr_ff <= reg_wdata[AW-1:0];
            `OBU_OFS_EVB_CFG: evb_cfg_ff <= reg_wdata[9:0];
            `OBU_OFS_BRK_CFG: brk_cfg_ff <= reg_wdata[4:0];
            `OBU_OFS_TRC_CFG: trc_cfg_ff <= reg_wdata[8:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Trace capture
   // ------------------------------------------------------------
   logic trc_on, trc_start, trc_stop, trc_pick, trc_wr;
   logic [EW-1:0] trc_entry;
   logic [2:0] stop_sel;
   assign trc_on = trc_cfg_ff[`OBU_TRC_EN];
   assign stop_sel = trc_cfg_ff[`OBU_TRC_STOP_LSB +: 3];
   assign trc_start = trc_on && ((trc_cfg_ff[`OBU_TRC_START_LSB +: 3]
      == 3'(obu_pkg::OBU_EC_NONE)) ? run_start
      : (running && ev_sel(trc_cfg_ff[`OBU_TRC_START_LSB +: 3], ev_vec)));
   assign trc_stop = core_halt_ack
      || ((stop_sel == 3'(obu_pkg::OBU_EC_FULL)) && trc_full)
      || ev_sel(stop_sel, ev_vec);
   assign trc_pick = trc_cfg_ff[`OBU_TRC_PICK] ? (a_hit || b_hit)
                                               : a_hit;
   // One mode bit selects the entry source; modes cannot overlap
   assign trc_wr = trc_act_ff && !trc_full
      && (trc_cfg_ff[`OBU_TRC_MODE] ? trc_pick : br_valid);
   assign trc_entry = trc_cfg_ff[`OBU_TRC_MODE]
      ? {dacc_write, 4'h0, dacc_data, dacc_addr}
      : {1'b0, br_dst, br_src};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trc_act_ff <= 1'b0;
      end else if (trc_stop) begin
         trc_act_ff <= 1'b0;
      end else if (trc_start) begin
         trc_act_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trc_cnt_ff <= '0;
      end else if (ctl_wr && reg_wdata[`OBU_CTRL_TCLR] && cfg_ok) begin
         trc_cnt_ff <= '0;
      end else if (trc_wr) begin
         trc_cnt_ff <= trc_cnt_ff + PW'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (trc_wr) begin
         trc_mem_ff[trc_cnt_ff[IW-1:0]] <= trc_entry;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trc_idx_ff <= '0;
      end else if (reg_wr && reg_addr == `OBU_OFS_TRC_IDX) begin
         trc_idx_ff <= reg_wdata[IW-1:0];
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [31:0] nxt_rdata;
   logic [EW-1:0] rd_entry;
   assign rd_entry = trc_mem_ff[trc_idx_ff];
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (reg_addr)
         `OBU_OFS_STATUS: nxt_rdata = {16'h0000, 8'(trc_cnt_ff),
            trc_full, cause_ff[4:0], state_ff};
         `OBU_OFS_PC_EN: nxt_rdata = 32'(pc_en_ff);
         `OBU_OFS_EVA_ADDR: nxt_rdata = 32'(eva_addr_ff);
         `OBU_OFS_EVA_CFG: nxt_rdata = 32'(eva_cfg_ff);
         `OBU_OFS_EVA_DATA: nxt_rdata = {eva_dmask_ff, eva_data_ff};
         `OBU_OFS_EVB_ADDR: nxt_rdata = 32'(evb_addr_ff);
         `OBU_OFS_EVB_CFG: nxt_rdata = 32'(evb_cfg_ff);
         `OBU_OFS_BRK_CFG: nxt_rdata = 32'(brk_cfg_ff);
         `OBU_OFS_TRC_CFG: nxt_rdata = {22'h0, trc_act_ff, trc_cfg_ff};
         `OBU_OFS_TRC_IDX: nxt_rdata = 32'(trc_idx_ff);
         `OBU_OFS_TRC_LO: nxt_rdata = rd_entry[31:0];
         `OBU_OFS_TRC_HI: nxt_rdata = 32'(rd_entry[EW-1:32]);
         default: begin
            for (int i = 0; i < NPC; i++) begin
               if (reg_addr == (`OBU_OFS_PC_BASE + 8'(4 * i))) begin
                  nxt_rdata = 32'(pc_addr_ff[i]);
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_ff;
   assign halt_req = halt_ff;
   assign addr_match_req = amr_ff;
   assign core_resume = resume_ff;
   assign core_step = step_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   halt_held_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      halt_ff && !core_halt_ack && !halt_set |=> halt_ff)
      else $error("halt request dropped before acknowledge");
   force_halt_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      force_cmd && running |=> halt_ff)
      else $error("force halt not raised");
   pc_break_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      running && insn_valid && (|pc_hit) |=> amr_ff && halt_ff)
      else $error("fetch address break missed");
   cfg_lock_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      reg_wr && !cfg_ok |=> $stable(eva_cfg_ff) && $stable(brk_cfg_ff))
      else $error("config changed while running");
   step_first_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      cfg_ok && resume_cmd && bp_cause |=> step_ff && resume_ff
         ##1 !resume_ff)
      else $error("resume from breakpoint did not step");
   tfull_brk_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      tfull_brk |=> halt_ff)
      else $error("trace full break missed");
   data_pick_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      trc_wr && trc_cfg_ff[`OBU_TRC_MODE] |-> dacc_valid && (a_hit || b_hit))
      else $error("data trace without comparator match");
   full_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      trc_full && !ctl_wr |-> !trc_wr ##1 trc_cnt_ff == PW'(DEPTH))
      else $error("trace written past full");
endmodule

// File: bench/obu_core_model.sv
// Behavioural core: acknowledges halts, runs one step after a resume with core_step set
`timescale 1ns/1ps
module obu_core_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [3:0] ack_delay,
   input wire logic halt_req,
   input wire logic core_resume,
   input wire logic core_step,
   input wire logic brk_op_hit,
   output logic core_halt_ack
);
   logic halted_ff;
   logic stepping_ff;
   logic [3:0] wait_ff;
   // ------------------------------------------------------------
   // Debug state entry and single step
   // ------------------------------------------------------------
   // Delay is an input so one run sees both prompt and slow acks
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         halted_ff <= 1'b0;
         stepping_ff <= 1'b0;
         wait_ff <= 4'h0;
         core_halt_ack <= 1'b0;
      end else begin
         core_halt_ack <= 1'b0;
         // Break opcode is a pulse: run it with a zero delay
         if (!halted_ff && !stepping_ff && (halt_req || brk_op_hit)) begin
            wait_ff <= wait_ff + 4'h1;
            if (wait_ff >= ack_delay) begin
               halted_ff <= 1'b1;
               wait_ff <= 4'h0;
               core_halt_ack <= 1'b1;
            end
         end else if (halted_ff && core_resume) begin
            halted_ff <= 1'b0;
            stepping_ff <= core_step;
            wait_ff <= 4'h0;
         end else if (stepping_ff) begin
            wait_ff <= wait_ff + 4'h1;
            if (wait_ff == 4'h2) begin
               stepping_ff <= 1'b0;
               wait_ff <= 4'h0;
               core_halt_ack <= 1'b1;
            end
         end
      end
   end
endmodule

// File: bench/obu_top_bench.sv
// Self-checking bench of the break unit with a core model
`timescale 1ns/1ps
`include "obu_defines.svh"
module obu_top_bench;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, insn_valid = 1'b0, br_valid = 1'b0;
   logic dacc_valid = 1'b0, dacc_word = 1'b0, dacc_write = 1'b0;
   logic [19:0] insn_addr = 20'h0, dacc_addr = 20'h0;
   logic [19:0] br_src = 20'h0, br_dst = 20'h0;
   logic [15:0] dacc_data = 16'h0;
   logic [31:0] reg_rdata;
   logic halt_req, addr_match_req, core_resume, core_step, core_halt_ack;
   logic [3:0] ack_delay = 4'h1;
   logic last_step = 1'b0;
   logic sw_hit = 1'b0;
   int failures = 0, compares = 0, cycles = 0;
   always #50 sys_clk = ~sys_clk;
   obu_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .insn_valid(insn_valid), .insn_addr(insn_addr),
      .dacc_valid(dacc_valid), .dacc_addr(dacc_addr), .dacc_data(dacc_data),
      .dacc_word(dacc_word), .dacc_write(dacc_write), .br_valid(br_valid),
      .br_src(br_src), .br_dst(br_dst), .debug_break_opcode_hit(sw_hit),
      .core_halt_ack(core_halt_ack), .halt_req(halt_req),
      .addr_match_req(addr_match_req), .core_resume(core_resume),
      .core_step(core_step));
   obu_core_model i_core (.sys_clk(sys_clk), .resetn(resetn),
      .ack_delay(ack_delay), .halt_req(halt_req), .core_resume(core_resume),
      .core_step(core_step), .brk_op_hit(sw_hit),
      .core_halt_ack(core_halt_ack));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (core_resume === 1'b1) last_step <= core_step;
      cycles = cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         end_sim();
      end
   end
   task end_sim;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input string n, input logic [31:0] got, input logic [31:0] ex);
      compares++;
      if (got !== ex) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, ex, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task rd_check(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      check(n, d, e);
   endtask
   task access(input logic [19:0] a, input logic [15:0] d, input logic w,
               input logic wt);
      @(posedge sys_clk);
      dacc_valid <= 1'b1;
      dacc_addr <= a;
      dacc_data <= d;
      dacc_word <= w;
      dacc_write <= wt;
      @(posedge sys_clk);
      dacc_valid <= 1'b0;
   endtask
   task watch(output logic seen);
      #1 seen = (halt_req === 1'b1);
      repeat (2) begin
         @(posedge sys_clk);
         #1 if (halt_req === 1'b1) seen = 1'b1;
      end
   endtask
   task wait_state(input logic [1:0] s, output logic [31:0] st);
      for (int i = 0; i < 40; i++) begin
         rd(`OBU_OFS_STATUS, st);
         if (st[1:0] === s) break;
      end
   endtask
   task resume;
      wr(`OBU_OFS_CTRL, 32'h2);
      repeat (3) @(posedge sys_clk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      rd_check("status", `OBU_OFS_STATUS, 32'h0);
      rd_check("eva cfg", `OBU_OFS_EVA_CFG, 32'h0);
      rd_check("eva data", `OBU_OFS_EVA_DATA, 32'hFFFF0000);
   endtask
   task t_pc;
      logic s;
      logic [31:0] st;
      ack_delay <= 4'h6;
      wr(`OBU_OFS_PC_BASE + 8'h0C, 32'h01234);
      wr(`OBU_OFS_PC_EN, 32'h8);
      @(posedge sys_clk);
      insn_valid <= 1'b1;
      insn_addr <= 20'h01236;
      @(posedge sys_clk);
      insn_addr <= 20'h01234;
      @(posedge sys_clk);
      insn_valid <= 1'b0;
      #1 check("match req", addr_match_req, 1'b1);
      watch(s);
      check("pc halt", s, 1'b1);
      wait_state(2'h1, st);
      check("pc cause", st[3:0], 4'h9);
      wr(`OBU_OFS_PC_EN, 32'h0);
      resume();
      check("step", last_step, 1'b1);
      wait_state(2'h0, st);
      check("run", st[1:0], 2'h0);
   endtask
   task t_force;
      logic s;
      logic [31:0] st;
      ack_delay <= 4'h1;
      wr(`OBU_OFS_CTRL, 32'h1);
      watch(s);
      check("force halt", s, 1'b1);
      wait_state(2'h1, st);
      check("force cause", st[2:0], 3'h5);
      wr(`OBU_OFS_EVA_ADDR, 32'h00400);
      wr(`OBU_OFS_EVA_CFG, 32'h321);
      wr(`OBU_OFS_EVA_DATA, 32'h00FF005A);
      wr(`OBU_OFS_BRK_CFG, 32'h09);
      wr(`OBU_OFS_TRC_CFG, 32'h100);
      rd_check("brk cfg", `OBU_OFS_BRK_CFG, 32'h09);
      resume();
      check("no step", last_step, 1'b0);
      wait_state(2'h0, st);
      wr(`OBU_OFS_BRK_CFG, 32'h0C);
      rd_check("brk locked", `OBU_OFS_BRK_CFG, 32'h09);
   endtask
   localparam logic [19:0] cs_addr [5] = '{20'h00401, 20'h00400, 20'h00400,
      20'h00402, 20'h00401};
   localparam logic [15:0] cs_data [5] = '{16'h005A, 16'h005A, 16'h005B,
      16'h005A, 16'h125A};
   localparam logic [4:0] cs_word = 5'b00010;
   localparam logic [4:0] cs_wrt = 5'b11110;
   localparam logic [4:0] cs_hit = 5'b10000;
   task t_data;
      logic s;
      logic [31:0] st;
      @(posedge sys_clk);
      br_valid <= 1'b1;
      br_src <= 20'h0ABCD;
      br_dst <= 20'h12345;
      @(posedge sys_clk);
      br_valid <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         access(cs_addr[i], cs_data[i], cs_word[i], cs_wrt[i]);
         watch(s);
         check("data hit", s, cs_hit[i]);
      end
      wait_state(2'h1, st);
      check("data cause", st[4], 1'b1);
   endtask
   task t_seq;
      logic s;
      logic [31:0] st;
      wr(`OBU_OFS_EVB_ADDR, 32'h00800);
      wr(`OBU_OFS_EVB_CFG, 32'h240);
      wr(`OBU_OFS_EVA_DATA, 32'h0);
      wr(`OBU_OFS_BRK_CFG, 32'h0C);
      resume();
      wait_state(2'h0, st);
      access(20'h00400, 16'h0077, 1'b0, 1'b1);
      watch(s);
      check("a first", s, 1'b0);
      access(20'h00800, 16'h0001, 1'b1, 1'b0);
      watch(s);
      check("b arms", s, 1'b0);
      access(20'h00401, 16'h0077, 1'b0, 1'b1);
      watch(s);
      check("b then a", s, 1'b1);
      wait_state(2'h1, st);
   endtask
   task t_trace;
      logic [31:0] st;
      rd(`OBU_OFS_STATUS, st);
      check("trace count", st[15:8], 8'h01);
      wr(`OBU_OFS_TRC_IDX, 32'h0);
      rd_check("trace lo", `OBU_OFS_TRC_LO, 32'h3450ABCD);
      rd_check("trace hi", `OBU_OFS_TRC_HI, 32'h00000012);
   endtask
   task t_sw;
      logic [31:0] st;
      resume();
      wait_state(2'h0, st);
      ack_delay <= 4'h0;
      @(posedge sys_clk);
      sw_hit <= 1'b1;
      @(posedge sys_clk);
      sw_hit <= 1'b0;
      wait_state(2'h1, st);
      check("sw cause", st[6:0], 7'h41);
      resume();
      check("sw step", last_step, 1'b1);
      wait_state(2'h0, st);
   endtask
   task t_full;
      logic s;
      logic [31:0] st;
      wr(`OBU_OFS_CTRL, 32'h1);
      wait_state(2'h1, st);
      wr(`OBU_OFS_CTRL, 32'h4);
      wr(`OBU_OFS_TRC_CFG, 32'h1D1);
      wr(`OBU_OFS_BRK_CFG, 32'h10);
      resume();
      access(20'h00600, 16'h0000, 1'b0, 1'b1);
      for (int i = 0; i < 16; i++) begin
         access(i[0] ? 20'h00800 : 20'h00401, 16'(i), i[0], !i[0]);
      end
      watch(s);
      check("full halt", s, 1'b1);
      wait_state(2'h1, st);
      check("full status", st[15:0], 16'h10A1);
      check("halt drop", halt_req, 1'b0);
      wr(`OBU_OFS_TRC_IDX, 32'h0);
      rd_check("data lo", `OBU_OFS_TRC_LO, 32'h00000401);
      rd_check("data hi", `OBU_OFS_TRC_HI, 32'h00000100);
      wr(`OBU_OFS_TRC_IDX, 32'h1);
      rd_check("pick b", `OBU_OFS_TRC_LO, 32'h00100800);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_pc();
      t_force();
      t_data();
      t_seq();
      t_trace();
      t_sw();
      t_full();
      end_sim();
   end
endmodule
